// file: src/scp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"

// Behaviour
// - abort input asynchronously resets only the serial port controller.
// - abort high cancels transfer; new transfer only after abort low.
// - chip select active low; port takes part only while asserted.
// - in 3-wire mode the data pin is input only, never driven.
// - in 3-wire mode readback leaves on the dedicated output pin.
// - in 2-wire mode data pin is bidirectional, device drives readback.
// - in 2-wire mode the dedicated output pin stays unused.
// - hardware reset forces all state and control words to initial values.
// - update strobe rising edge copies buffer words to active words.
// - input data sampled on serial clock rising edge.
module scp_port #(
    parameter int DEPTH = `SCP_NUM_REGS,
    parameter int WIDTH = `SCP_REG_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_port_abort,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdio_in,
    input wire logic update_in,
    input wire logic two_wire,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_pin,
    output logic serial_out_pin_oe,
    output logic sync_clk_out,
    output logic busy,
    output logic [DEPTH*WIDTH-1:0] active_flat
);
    import scp_pkg::*;
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////
    // input synchronisers, abort kept raw for its async action
    logic [1:0] cs_sync, sclk_sync, sdio_sync, upd_sync;
    scp_pins_s pins;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            sdio_sync <= 2'h0;
            upd_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[0], cs_n};
            sclk_sync <= {sclk_sync[0], sclk};
            sdio_sync <= {sdio_sync[0], sdio_in};
            upd_sync <= {upd_sync[0], update_in};
        end
    end
    assign pins = '{cs_n: cs_sync[1], sclk: sclk_sync[1], sdio: sdio_sync[1],
                    abort: serial_port_abort, update: upd_sync[1]};

    ////////////////////////////////////////////////////////////////////
    // sync clock divider; update strobe sampled on its enable
    logic [1:0] div_reg, div_next;
    logic sync_en;
    logic upd_prev_reg, upd_prev_next;
    logic commit;
    always_comb begin
        div_next = div_reg + 2'h1;
        sync_en = (div_reg == 2'(`SCP_SYNC_DIV - 1));
        upd_prev_next = sync_en ? pins.update : upd_prev_reg;
        commit = sync_en && pins.update && !upd_prev_reg;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            upd_prev_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            upd_prev_reg <= upd_prev_next;
        end
    end
    assign sync_clk_out = div_reg[1];

    ////////////////////////////////////////////////////////////////////
    // serial port controller, cleared by hardware reset or abort
    wire ctl_rst = rst | pins.abort;
    scp_state_e state_reg, state_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic [7:0] shift_reg, shift_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic out_reg, out_next;
    logic wr_en;
    logic [WIDTH-1:0] rd_data;
    logic rise, fall, sel;

    always_comb begin
        sel = !pins.cs_n;
        rise = sel && pins.sclk && !sclk_prev_reg;
        fall = sel && !pins.sclk && sclk_prev_reg;
        sclk_prev_next = pins.sclk;
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        out_next = out_reg;
        wr_en = 1'b0;
        case (state_reg)
            SCP_IDLE: begin
                cnt_next = 3'h0;
                if (sel) begin
                    state_next = SCP_INSTR;
                end
            end
            SCP_INSTR: begin
                if (rise) begin
                    shift_next = {shift_reg[6:0], pins.sdio};
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7) begin
                        addr_next = AW'(shift_next[`SCP_ADDR_MSB:0]);
                        state_next = shift_next[`SCP_READ_BIT] ? SCP_RDATA : SCP_WDATA;
                    end
                end
            end
            SCP_WDATA: begin
                if (rise) begin
                    shift_next = {shift_reg[6:0], pins.sdio};
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7) begin
                        wr_en = 1'b1;
                        addr_next = addr_reg + AW'(1);
                    end
                end
            end
            SCP_RDATA: begin
                // load word on first falling edge, shift msb first
                if (fall) begin
                    if (cnt_reg == 3'h0) begin
                        out_next = rd_data[WIDTH-1];
                        shift_next = {rd_data[WIDTH-2:0], 1'b0};
                        addr_next = addr_reg + AW'(1);
                    end else begin
                        out_next = shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b0};
                    end
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            default: state_next = SCP_IDLE;
        endcase
        if (!sel) begin
            state_next = SCP_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge ctl_rst) begin
        if (ctl_rst) begin
            state_reg <= SCP_IDLE;
            sclk_prev_reg <= 1'b0;
            shift_reg <= 8'h00;
            cnt_reg <= 3'h0;
            addr_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sclk_prev_reg <= sclk_prev_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            out_reg <= out_next;
        end
    end

    scp_regfile #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) u_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_en),
        .wr_addr(addr_reg),
        .wr_data(shift_next),
        .commit(commit),
        .rd_addr(addr_reg),
        .rd_data(rd_data),
        .active_flat(active_flat)
    );

    ////////////////////////////////////////////////////////////////////
    // pin drivers; readback pin choice follows the wiring mode
    scp_drive_s drv;
    always_comb begin
        drv.sdio_out = out_reg;
        drv.sdio_oe = two_wire && state_reg == SCP_RDATA && sel;
        drv.ser_out = out_reg;
        drv.ser_oe = !two_wire && state_reg == SCP_RDATA && sel;
    end
    assign sdio_out = drv.sdio_out;
    assign sdio_oe = drv.sdio_oe;
    assign serial_out_pin = drv.ser_out;
    assign serial_out_pin_oe = drv.ser_oe;
    assign busy = state_reg != SCP_IDLE;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_three_wire_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !two_wire |-> !sdio_oe) else $error("data pin driven in 3-wire mode");
    chk_two_wire_sdo: assert property (@(posedge sys_clk) disable iff (rst)
        two_wire |-> !serial_out_pin_oe) else $error("dedicated output driven in 2-wire mode");
    chk_deselect_hiz: assert property (@(posedge sys_clk) disable iff (rst)
        cs_sync[1] |=> !sdio_oe && !serial_out_pin_oe) else $error("driver on while idle");
    chk_abort_cancel: assert property (@(posedge sys_clk) disable iff (rst)
        serial_port_abort |-> state_reg == SCP_IDLE) else $error("abort did not cancel");
    chk_readback_pin: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == SCP_RDATA && !two_wire && !cs_sync[1]) |-> serial_out_pin_oe)
        else $error("readback not on output pin");
    // strobe low at the previous sync enable, high at this one
    chk_commit_edge: assert property (@(posedge sys_clk) disable iff (rst)
        commit |-> sync_en && upd_sync[1] && !$past(upd_sync[1], 4))
        else $error("commit without strobe rise");
    sequence s_deselect;
        cs_sync[1] ##1 cs_sync[1];
    endsequence
    chk_deselect_idle: assert property (@(posedge sys_clk)
        disable iff (rst || serial_port_abort) s_deselect |-> state_reg == SCP_IDLE)
        else $error("active while deselected");
    // judged from the synchronised pins, not from the edge detector itself
    chk_write_edge: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en |-> !cs_sync[1] && sclk_sync[1] && !$past(sclk_sync[1]))
        else $error("write not on rising clock edge");
endmodule : scp_port
`default_nettype wire

// file: src/scp_map.svh
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// frame layout: one instruction byte, then data bytes
`define SCP_INSTR_BITS 8
`define SCP_READ_BIT 7
`define SCP_ADDR_MSB 4
// number of addressable control words
`define SCP_NUM_REGS 32
`define SCP_REG_WIDTH 8
// all control words clear to this value
`define SCP_REG_RESET 8'h00
// sync clock is the system clock divided by four
`define SCP_SYNC_DIV 4

`endif

// file: src/scp_pkg.sv
`default_nettype none
package scp_pkg;
    typedef enum {SCP_IDLE, SCP_INSTR, SCP_WDATA, SCP_RDATA} scp_state_e;

    // pin inputs after synchronising, abort left raw
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdio;
        logic abort;
        logic update;
    } scp_pins_s;

    // two-way and output drivers
    typedef struct packed {
        logic sdio_out;
        logic sdio_oe;
        logic ser_out;
        logic ser_oe;
    } scp_drive_s;
endpackage : scp_pkg
`default_nettype wire

// file: src/scp_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"

module scp_regfile #(
    parameter int DEPTH = `SCP_NUM_REGS,
    parameter int WIDTH = `SCP_REG_WIDTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic commit,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    output logic [DEPTH*WIDTH-1:0] active_flat
);
    logic [WIDTH-1:0] buf_reg [DEPTH];
    logic [WIDTH-1:0] act_reg [DEPTH];
    logic [WIDTH-1:0] rd_reg;

    // buffer and active copies per word
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    buf_reg[i] <= `SCP_REG_RESET;
                    act_reg[i] <= `SCP_REG_RESET;
                end else begin
                    if (wr_en && wr_addr == AW'(i)) begin
                        buf_reg[i] <= wr_data;
                    end
                    if (commit) begin
                        act_reg[i] <= buf_reg[i];
                    end
                end
            end
            assign active_flat[i*WIDTH +: WIDTH] = act_reg[i];
        end
    endgenerate

    // readback from the active copy, registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_reg <= `SCP_REG_RESET;
        end else begin
            rd_reg <= act_reg[rd_addr];
        end
    end
    assign rd_data = rd_reg;
endmodule : scp_regfile
`default_nettype wire

// file: tb/scp_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// host controller model: drives select, clock and data pin
module scp_host (
    input wire logic sys_clk,
    input wire logic two_wire,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic out_pin,
    input wire logic out_pin_oe,
    output var logic cs_n,
    output var logic sclk,
    output logic sdio_line
);
    logic host_en = 1'b1;
    logic host_val = 1'b0;
    logic last_reg = 1'b0;
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    // released line flips, so a stale level never reads as valid
    assign sdio_line = dev_oe ? dev_out : (host_en ? host_val : ~last_reg);
    // last level seen on the shared line
    always @(posedge sys_clk) last_reg <= sdio_line;
    ////////////////////////////////////////////////////////////
    // one frame: instruction byte, one data byte, msb first
    task automatic frame(input logic sel, input logic rd, input logic [4:0] addr,
                         input logic [7:0] wdata, input int hp, output logic [7:0] rdata);
        logic [15:0] word;
        word = {rd, 2'b00, addr, wdata};
        @(posedge sys_clk);
        cs_n <= ~sel;
        repeat (hp) @(posedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
            host_en <= !(rd && two_wire && i < 8);
            host_val <= word[i];
            sclk <= 1'b0;
            repeat (hp) @(posedge sys_clk);
            // undriven output pin reads unknown, so a missing driver fails the compare
            rdata[i % 8] = two_wire ? sdio_line : (out_pin_oe ? out_pin : 1'bx);
            sclk <= 1'b1;
            repeat (hp) @(posedge sys_clk);
        end
        sclk <= 1'b0;
        host_en <= 1'b1;
        repeat (hp) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (hp) @(posedge sys_clk);
    endtask : frame
endmodule : scp_host
`default_nettype wire

// file: tb/scp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_map.svh"
module scp_port_test;
    typedef struct {logic tw; logic [4:0] addr; logic [7:0] data;} scp_row_s;
    scp_row_s rows[4] = '{'{1'b0, 5'h00, 8'hA5}, '{1'b0, 5'h1F, 8'h3C},
                          '{1'b1, 5'h07, 8'h5A}, '{1'b1, 5'h10, 8'hFF}};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic serial_port_abort = 1'b0;
    logic update_in = 1'b0;
    logic two_wire = 1'b0;
    logic cs_n, sclk, sdio_line, sdio_out, sdio_oe, serial_out_pin, serial_out_pin_oe, busy;
    logic sync_clk_out, sync_s;
    logic [255:0] active_flat;
    logic [7:0] rd_val;
    logic [3:0] cs_hist = 4'h0;
    int failures = 0;
    int n_checks = 0;
    int mon_err = 0;
    int cyc = 0;
    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;
    scp_port u_dut (.sys_clk, .rst, .serial_port_abort, .cs_n, .sclk,
        .sdio_in(sdio_line), .update_in, .two_wire, .sdio_out, .sdio_oe,
        .serial_out_pin, .serial_out_pin_oe, .sync_clk_out, .busy, .active_flat);
    scp_host u_host (.sys_clk, .two_wire, .dev_out(sdio_out), .dev_oe(sdio_oe),
        .out_pin(serial_out_pin), .out_pin_oe(serial_out_pin_oe), .cs_n, .sclk, .sdio_line);
    ////////////////////////////////////////////////////////////
    // drivers off by mode or by select; select gets 4 cycles of sync slack
    always @(posedge sys_clk) begin
        cs_hist <= {cs_hist[2:0], cs_n};
        if (!rst && ((sdio_oe === 1'b1 && (!two_wire || &cs_hist)) ||
                     (serial_out_pin_oe === 1'b1 && (two_wire || &cs_hist)))) begin
            mon_err <= mon_err + 1;
        end
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            $display("[ERR] %0t: timeout", $time);
            results();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] word(input int i);
        return active_flat[i*8+:8];
    endfunction : word
    // strobe held over two sync periods, then settle
    task automatic pulse_update();
        @(posedge sys_clk);
        update_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        update_in <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : pulse_update
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        u_host.frame(1'b1, 1'b0, addr, data, 4, rd_val);
    endtask : wr
    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 32; i++) chk(word(i), 8'h00);
        // sync clock flips every half divide, sampled away from its launching edge
        @(negedge sys_clk);
        sync_s = sync_clk_out;
        repeat (`SCP_SYNC_DIV / 2) @(negedge sys_clk);
        chk({7'h00, sync_clk_out}, {7'h00, ~sync_s});
        repeat (`SCP_SYNC_DIV / 2) @(negedge sys_clk);
        chk({7'h00, sync_clk_out}, {7'h00, sync_s});
        $display("test reset values done");
        for (int r = 0; r < 4; r++) begin
            two_wire <= rows[r].tw;
            wr(rows[r].addr, rows[r].data);
            pulse_update();
            chk(word(rows[r].addr), rows[r].data);
            u_host.frame(1'b1, 1'b1, rows[r].addr, 8'h00, 50, rd_val);
            chk(rd_val, rows[r].data);
            $display("test row %0d done", r);
        end
        // buffered write stays hidden until the strobe
        wr(5'h03, 8'h77);
        repeat (20) @(posedge sys_clk);
        chk(word(3), 8'h00);
        u_host.frame(1'b0, 1'b0, 5'h04, 8'hE1, 4, rd_val);
        pulse_update();
        chk(word(3), 8'h77);
        chk(word(4), 8'h00);
        $display("test strobe and deselect done");
        // abort in mid instruction, held to frame end
        fork
            u_host.frame(1'b1, 1'b0, 5'h05, 8'hC3, 4, rd_val);
            begin
                repeat (40) @(posedge sys_clk);
                serial_port_abort <= 1'b1;
                repeat (10) @(posedge sys_clk);
                chk({7'h00, busy}, 8'h00);
            end
        join
        serial_port_abort <= 1'b0;
        pulse_update();
        chk(word(5), 8'h00);
        chk(word(3), 8'h77);
        wr(5'h05, 8'hC3);
        pulse_update();
        chk(word(5), 8'hC3);
        $display("test abort done");
        // hardware reset in mid run
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(word(3), 8'h00);
        chk(word(5), 8'h00);
        chk({7'h00, mon_err != 0}, 8'h00);
        $display("test second reset done");
        results();
    end
endmodule : scp_port_test
`default_nettype wire
